// *** core/rcs_pkg.sv ***
// Constants and state types for the reset cause status block
// Summary of operation
// - An 8-bit cause register, read-only to software, names the source of the last reset.
// - A reset forced through the debug force bit without low voltage in the same cycle leaves every cause flag cleared.
// - With the watchdog enabled, writing any value but 0x55 or 0xaa to the cause address resets.
// - Writing 0x55 then 0xaa clears the watchdog counter and leaves the cause flags alone.
// - Power-on reset sets bit 7 and bit 1 and clears all other flags.
// - Low-voltage reset keeps bit 7, sets bit 1 and clears the rest.
// - Any other reset clears bits 7 and 1 and, unless the debug force bit is set, sets each source flag active at reset entry.
// - Bit 6 is set when the reset came from a low level on the external reset pin.
// - Bit 5 marks a watchdog timeout; timeout select 0 blocks that source.
// - Bit 4 marks a reset from an unimplemented or illegal opcode.
// - The stop instruction counts as illegal while stop enable is 0.
// - The background instruction counts as illegal while debug mode enable is 0.
package rcs_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] CAUSE_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  localparam logic [7:0] WD_COUNT_OFS = 8'h10;
  localparam logic [7:0] DBG_FORCE_OFS = 8'h14;

  // ==========================================================
  // Cause register bits
  localparam int POWER_ON_BIT = 7;
  localparam int PIN_BIT = 6;
  localparam int WATCHDOG_BIT = 5;
  localparam int ILL_OPCODE_BIT = 4;
  localparam int ILL_ADDR_BIT = 3;
  localparam int LOW_VOLT_BIT = 1;
  localparam logic [7:0] CAUSE_MASK = 8'hfa;
  localparam logic [7:0] CAUSE_POR_VAL = 8'h82;

  // ==========================================================
  // Control and debug force register fields
  localparam int WD_SEL_LSB = 0;
  localparam int STOP_EN_BIT = 2;
  localparam int DBG_EN_BIT = 3;
  localparam int DBG_FORCE_BIT = 0;
  localparam logic [1:0] WD_SEL_RST = 2'h3;

  // ==========================================================
  // Interrupt event bits
  localparam int IRQ_RESET_BIT = 0;
  localparam int IRQ_SERVICE_BIT = 1;
  localparam int IRQ_BADWR_BIT = 2;
  localparam int IRQ_W = 3;

  // ==========================================================
  // Service sequence values
  localparam logic [7:0] SERVICE_FIRST = 8'h55;
  localparam logic [7:0] SERVICE_SECOND = 8'haa;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_HOLD_NS = 160;
  localparam logic [4:0] RESET_HOLD_CYC = 5'(RESET_HOLD_NS / CLK_PERIOD_NS);
  localparam int WD_SHORT_CYC = 1024;
  localparam int WD_MID_CYC = 8192;
  localparam int WD_LONG_CYC = 65536;
  localparam int WD_CNT_W = 17;

  typedef enum logic [0:0] {
    RCS_RUN,
    RCS_HOLD
  } rcs_phase_t;

endpackage : rcs_pkg

// *** core/rcs_watchdog.sv ***
// Watchdog counter with selectable timeout
`timescale 1ns/1ps
module rcs_watchdog
#(
  parameter int unsigned TimeoutMid = rcs_pkg::WD_MID_CYC,
  parameter int unsigned TimeoutLong = rcs_pkg::WD_LONG_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic kick,
  input wire logic [1:0] timeoutSel,
  output logic expired,
  output logic [rcs_pkg::WD_CNT_W-1:0] count
);
  import rcs_pkg::*;

  typedef struct packed {
    logic [WD_CNT_W-1:0] count;
    logic expired;
  } rcs_wd_state_t;

  rcs_wd_state_t wd_r;
  rcs_wd_state_t wd_nxt;
  logic [WD_CNT_W-1:0] limit;

  // ==========================================================
  // Timeout limit
  always_comb
  begin
    unique case (timeoutSel)
      2'h1: limit = WD_CNT_W'(WD_SHORT_CYC - 1);
      2'h2: limit = WD_CNT_W'(TimeoutMid - 1);
      default: limit = WD_CNT_W'(TimeoutLong - 1);
    endcase
  end

  // ==========================================================
  // Counter
  always_comb
  begin
    wd_nxt = wd_r;
    wd_nxt.expired = 1'b0;
    if (kick || timeoutSel == 2'h0)
    begin
      wd_nxt.count = '0;
    end
    else if (wd_r.count >= limit)
    begin
      wd_nxt.count = '0;
      wd_nxt.expired = 1'b1;
    end
    else
    begin
      wd_nxt.count = wd_r.count + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wd_r <= '0;
    end
    else
    begin
      wd_r <= wd_nxt;
    end
  end

  assign expired = wd_r.expired;
  assign count = wd_r.count;

endmodule : rcs_watchdog

// *** core/rcs_reset_cause_status.sv ***
// Reset cause capture, reset request and watchdog service over APB
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module rcs_reset_cause_status
#(
  parameter int unsigned TimeoutMid = rcs_pkg::WD_MID_CYC,
  parameter int unsigned TimeoutLong = rcs_pkg::WD_LONG_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic resetPin_n,
  input wire logic lowVoltage,
  input wire logic opcodeIllegal,
  input wire logic stopExec,
  input wire logic backgroundExec,
  input wire logic illegalAddress,
  output logic systemReset,
  output logic stopEnable,
  output logic debugModeEnable,
  output logic irq
);
  import rcs_pkg::*;

  typedef struct packed {
    rcs_phase_t phase;
    logic [4:0] holdCnt;
    logic [7:0] cause;
    logic [1:0] wdSel;
    logic stopEn;
    logic dbgEn;
    logic dbgForce;
    logic armed;
    logic kick;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic pinMeta;
    logic pinSync_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } rcs_state_t;

  rcs_state_t s_r;
  rcs_state_t s_nxt;
  logic wdExpired;
  logic [WD_CNT_W-1:0] wdCount;

  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = addr == CAUSE_OFS || addr == CTRL_OFS || addr == IRQ_STAT_OFS
      || addr == IRQ_MASK_OFS || addr == WD_COUNT_OFS || addr == DBG_FORCE_OFS;
  endfunction : isMapped

  // ==========================================================
  // Watchdog
  rcs_watchdog #(
    .TimeoutMid(TimeoutMid),
    .TimeoutLong(TimeoutLong)
  ) u_watchdog (
    .clk(clk),
    .reset_n(reset_n),
    .kick(s_r.kick),
    .timeoutSel(s_r.wdSel),
    .expired(wdExpired),
    .count(wdCount)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    logic accessDone;
    logic wrCommit;
    logic badWrite;
    logic service;
    logic opSrc;
    logic anySrc;
    logic [7:0] wbyte;
    logic [IRQ_W-1:0] irqSet;
    logic [IRQ_W-1:0] irqClr;
    accessDone = 1'b0;
    wrCommit = 1'b0;
    badWrite = 1'b0;
    service = 1'b0;
    opSrc = 1'b0;
    anySrc = 1'b0;
    wbyte = pwdata[7:0];
    irqSet = '0;
    irqClr = '0;
    s_nxt = s_r;
    s_nxt.kick = 1'b0;
    s_nxt.dbgForce = 1'b0;
    s_nxt.pinMeta = resetPin_n;
    s_nxt.pinSync_n = s_r.pinMeta;

    // Two-cycle access: data set up, then pready
    accessDone = psel && penable && s_r.pready;
    wrCommit = accessDone && pwrite && isMapped(paddr);
    s_nxt.pready = psel && penable && !s_r.pready;
    if (psel && penable && !s_r.pready)
    begin
      s_nxt.pslverr = !isMapped(paddr);
      s_nxt.prdata = '0;
      if (!pwrite)
      begin
        unique case (paddr)
          CAUSE_OFS: s_nxt.prdata = {24'h0, s_r.cause & CAUSE_MASK};
          CTRL_OFS: s_nxt.prdata = {28'h0, s_r.dbgEn, s_r.stopEn, s_r.wdSel};
          IRQ_STAT_OFS: s_nxt.prdata = {29'h0, s_r.irqStat};
          IRQ_MASK_OFS: s_nxt.prdata = {29'h0, s_r.irqMask};
          WD_COUNT_OFS: s_nxt.prdata = 32'(wdCount);
          default: s_nxt.prdata = '0;
        endcase
      end
    end

    // ==========================================================
    // Register writes
    if (wrCommit)
    begin
      unique case (paddr)
        CAUSE_OFS:
        begin
          if (wbyte == SERVICE_FIRST)
          begin
            s_nxt.armed = 1'b1;
          end
          else if (wbyte == SERVICE_SECOND)
          begin
            s_nxt.armed = 1'b0;
            service = s_r.armed;
          end
          else
          begin
            // Other value is a watchdog reset unless timeout select is 0
            s_nxt.armed = 1'b0;
            badWrite = s_r.wdSel != 2'h0;
          end
        end
        CTRL_OFS:
        begin
          s_nxt.wdSel = pwdata[WD_SEL_LSB +: 2];
          s_nxt.stopEn = pwdata[STOP_EN_BIT];
          s_nxt.dbgEn = pwdata[DBG_EN_BIT];
        end
        IRQ_STAT_OFS: irqClr = pwdata[IRQ_W-1:0];
        IRQ_MASK_OFS: s_nxt.irqMask = pwdata[IRQ_W-1:0];
        DBG_FORCE_OFS: s_nxt.dbgForce = pwdata[DBG_FORCE_BIT];
        default: s_nxt.armed = s_r.armed;
      endcase
    end
    s_nxt.kick = service;

    // ==========================================================
    // Reset sources
    // Stop illegal while disabled
    opSrc = opcodeIllegal || (stopExec && !s_r.stopEn) || (backgroundExec && !s_r.dbgEn);
    anySrc = lowVoltage || s_r.dbgForce || !s_r.pinSync_n || wdExpired || badWrite
      || opSrc || illegalAddress;

    unique case (s_r.phase)
      RCS_RUN:
      begin
        if (anySrc)
        begin
          s_nxt.phase = RCS_HOLD;
          s_nxt.holdCnt = RESET_HOLD_CYC;
          s_nxt.armed = 1'b0;
          s_nxt.kick = 1'b1;
          s_nxt.wdSel = WD_SEL_RST;
          s_nxt.stopEn = 1'b0;
          s_nxt.dbgEn = 1'b0;
          irqSet[IRQ_RESET_BIT] = 1'b1;
          s_nxt.cause = '0;
          if (lowVoltage)
          begin
            s_nxt.cause[POWER_ON_BIT] = s_r.cause[POWER_ON_BIT];
            s_nxt.cause[LOW_VOLT_BIT] = 1'b1;
          end
          else if (!s_r.dbgForce)
          begin
            s_nxt.cause[PIN_BIT] = !s_r.pinSync_n;
            s_nxt.cause[WATCHDOG_BIT] = wdExpired || badWrite;
            s_nxt.cause[ILL_OPCODE_BIT] = opSrc;
            s_nxt.cause[ILL_ADDR_BIT] = illegalAddress;
          end
        end
      end
      RCS_HOLD:
      begin
        s_nxt.kick = 1'b1;
        s_nxt.holdCnt = s_r.holdCnt - 5'h1;
        if (s_r.holdCnt == 5'h1)
        begin
          s_nxt.phase = RCS_RUN;
        end
      end
    endcase

    irqSet[IRQ_SERVICE_BIT] = service;
    irqSet[IRQ_BADWR_BIT] = badWrite;
    // Set wins over clear
    s_nxt.irqStat = (s_r.irqStat & ~irqClr) | irqSet;
    s_nxt.irq = |(s_nxt.irqStat & s_nxt.irqMask);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_r <= '0;
      s_r.cause <= CAUSE_POR_VAL;
      s_r.wdSel <= WD_SEL_RST;
      s_r.pinMeta <= 1'b1;
      s_r.pinSync_n <= 1'b1;
      s_r.phase <= RCS_RUN;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // Cause flags only read
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign systemReset = s_r.phase == RCS_HOLD;
  assign stopEnable = s_r.stopEn;
  assign debugModeEnable = s_r.dbgEn;
  assign irq = s_r.irq;

endmodule : rcs_reset_cause_status

// *** testbench/rcs_asserts.sv ***
// Port checker for the reset cause status block
`timescale 1ns/1ps
module rcs_status_chk
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic resetPin_n,
  input wire logic lowVoltage,
  input wire logic opcodeIllegal,
  input wire logic stopExec,
  input wire logic backgroundExec,
  input wire logic illegalAddress,
  input wire logic systemReset,
  input wire logic stopEnable,
  input wire logic debugModeEnable
);
  logic [4:0] holdCnt_r;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ==========================================================
  // Hold length counter
  always_ff @(posedge clk)
  begin
    if (!reset_n || !systemReset)
      holdCnt_r <= 5'h00;
    else
      holdCnt_r <= holdCnt_r + 5'h01;
  end

  a_access_one_wait: assert property (
    $rose(penable) && psel |-> !pready ##1 pready ##1 !pready)
    else $error("access answer timing wrong");
  a_unmapped_err: assert property (
    pready && paddr > 8'h14 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_cause_zero_bits: assert property (
    pready && !pwrite && paddr == 8'h00 |-> prdata[31:8] == 24'h0 && !prdata[2] && !prdata[0])
    else $error("cause read has stray bits");
  a_opcode_reset: assert property (
    opcodeIllegal && !systemReset |=> systemReset)
    else $error("illegal opcode gave no reset");
  a_stop_reset: assert property (
    stopExec && !stopEnable && !systemReset |=> systemReset)
    else $error("disabled stop gave no reset");
  a_background_instr_reset: assert property (
    backgroundExec && !debugModeEnable && !systemReset |=> systemReset)
    else $error("disabled background gave no reset");
  a_addr_reset: assert property (
    illegalAddress && !systemReset |=> systemReset)
    else $error("illegal address gave no reset");
  a_lowv_reset: assert property (
    lowVoltage && !systemReset |=> systemReset)
    else $error("low voltage gave no reset");
  a_pin_reset: assert property (
    $fell(resetPin_n) && !systemReset |-> ##[1:4] systemReset)
    else $error("pin gave no reset");
  a_hold_length: assert property (
    $fell(systemReset) |-> holdCnt_r == 5'h10)
    else $error("reset hold length wrong");
endmodule : rcs_status_chk

bind rcs_reset_cause_status rcs_status_chk chk_u (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .resetPin_n(resetPin_n), .lowVoltage(lowVoltage), .opcodeIllegal(opcodeIllegal),
  .stopExec(stopExec), .backgroundExec(backgroundExec), .illegalAddress(illegalAddress),
  .systemReset(systemReset), .stopEnable(stopEnable), .debugModeEnable(debugModeEnable));

// *** testbench/tb_reset_cause_status.sv ***
// Self-checking bench for the reset cause status block
`timescale 1ns/1ps
module tb_reset_cause_status;
  import rcs_pkg::*;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, resetPin_n;
  logic systemReset, stopEnable, debugModeEnable, irq, lastErr, p7;
  logic [7:0] paddr;
  logic [4:0] src;
  logic [31:0] pwdata, prdata, rd, seed, v;
  int errCount, comparisons, n, k, i;

  rcs_reset_cause_status #(.TimeoutMid(64), .TimeoutLong(3000)) dut_u (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .resetPin_n(resetPin_n), .lowVoltage(src[4]), .opcodeIllegal(src[0]),
    .stopExec(src[1]), .backgroundExec(src[2]), .illegalAddress(src[3]),
    .systemReset(systemReset), .stopEnable(stopEnable),
    .debugModeEnable(debugModeEnable), .irq(irq));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // Cause after one pulse of source k
  function automatic logic [31:0] expCause(input int k, input logic p);
    return (k == 4) ? {24'h0, p, 7'h02} : ((k == 3) ? 32'h08 : 32'h10);
  endfunction : expCause

  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task bound(input int c, input int lim);
    if (c >= lim)
    begin
      errCount++;
      conclude();
    end
  endtask : bound

  task chkWord(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      errCount++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chkWord

  task chkBit(input string nm, input logic e, input logic g);
    chkWord(nm, {31'h0, e}, {31'h0, g});
  endtask : chkBit

  // ==========================================================
  // APB master
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge clk);
    bound(n, 20);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chkWord(nm, e, rd);
  endtask : rdc

  task pulse(input int s);
    @(posedge clk);
    src[s] <= 1'b1;
    @(posedge clk);
    src <= 5'h00;
  endtask : pulse

  task waitRst(input logic e);
    for (n = 0; n < 8 && systemReset !== 1'b1; n++)
      @(posedge clk);
    chkBit("reset", e, systemReset);
    for (n = 0; n < 40 && systemReset !== 1'b0; n++)
      @(posedge clk);
    bound(n, 40);
  endtask : waitRst

  initial
  begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, src} = '0;
    resetPin_n = 1'b1;
    seed = 32'hd335;
    errCount = 0;
    comparisons = 0;
    p7 = 1'b1;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rdc(CAUSE_OFS, 32'h82, "cause");
    rdc(CTRL_OFS, 32'h3, "ctrl");
    rdc(8'h20, 32'h0, "unmapped");
    chkBit("slverr", 1'b1, lastErr);
    wr(CAUSE_OFS, 32'h55);
    wr(CAUSE_OFS, 32'haa);
    rdc(CAUSE_OFS, 32'h82, "cause");
    apb(1'b0, WD_COUNT_OFS, 32'h0);
    chkBit("wdcount", 1'b1, rd < 32'h10);
    for (i = 0; i < 10; i++)
    begin
      seed = xs(seed);
      k = (i < 5) ? i : int'(seed % 5);
      repeat (seed[10:8]) @(posedge clk);
      pulse(k);
      waitRst(1'b1);
      rdc(CAUSE_OFS, expCause(k, p7), "cause");
      p7 = (k == 4) ? p7 : 1'b0;
    end
    @(posedge clk);
    resetPin_n <= 1'b0;
    repeat (4) @(posedge clk);
    resetPin_n <= 1'b1;
    waitRst(1'b1);
    rdc(CAUSE_OFS, 32'h40, "cause");
    wr(DBG_FORCE_OFS, 32'h1);
    waitRst(1'b1);
    rdc(CAUSE_OFS, 32'h0, "cause");
    seed = xs(seed);
    v = (seed[7:0] == 8'h55 || seed[7:0] == 8'haa) ? 32'h1 : seed;
    wr(CAUSE_OFS, v);
    waitRst(1'b1);
    rdc(CAUSE_OFS, 32'h20, "cause");
    wr(CTRL_OFS, 32'hc);
    wr(CAUSE_OFS, v);
    waitRst(1'b0);
    chkBit("stopen", 1'b1, stopEnable);
    chkBit("dbgen", 1'b1, debugModeEnable);
    pulse(1);
    waitRst(1'b0);
    pulse(2);
    waitRst(1'b0);
    rdc(CAUSE_OFS, 32'h20, "cause");
    wr(IRQ_STAT_OFS, 32'h7);
    wr(IRQ_MASK_OFS, 32'h1);
    @(posedge clk);
    chkBit("irq", 1'b0, irq);
    wr(CTRL_OFS, 32'h2);
    wr(CAUSE_OFS, 32'h55);
    wr(CAUSE_OFS, 32'haa);
    for (k = 0; k < 200 && systemReset !== 1'b1; k++)
      @(posedge clk);
    chkBit("timeout", 1'b1, k >= 56 && k <= 72);
    waitRst(1'b1);
    rdc(CAUSE_OFS, 32'h20, "cause");
    chkBit("irq", 1'b1, irq);
    rdc(IRQ_STAT_OFS, 32'h3, "irqstat");
    wr(IRQ_STAT_OFS, 32'h1);
    repeat (2) @(posedge clk);
    chkBit("irq", 1'b0, irq);
    // ==========================================================
    // Short and long timeout selects
    for (i = 1; i < 4; i += 2)
    begin
      wr(CTRL_OFS, 32'(i));
      wr(CAUSE_OFS, 32'h55);
      wr(CAUSE_OFS, 32'haa);
      for (k = 0; k < 3200 && systemReset !== 1'b1; k++)
        @(posedge clk);
      n = (i == 1) ? WD_SHORT_CYC : 3000;
      chkBit("timeout", 1'b1, k >= n && k <= n + 8);
      waitRst(1'b1);
    end
    // ==========================================================
    // Power-on reset in mid-run
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rdc(CAUSE_OFS, 32'h82, "cause");
    rdc(CTRL_OFS, 32'h3, "ctrl");
    chkBit("irq", 1'b0, irq);
    conclude();
  end
endmodule : tb_reset_cause_status
